// ---- logic/branch_pkg.sv ----
// Shared types and constants for the conditional relative-branch unit.
// Assumes a single core clock; flags and requests come from logic on that clock.
package branch_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int unsigned PC_W   = 16;
   localparam int unsigned OFS_W  = 7;
   localparam int unsigned SEXT_W = PC_W - OFS_W;
   localparam int unsigned COND_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and fixed steps
   localparam logic [PC_W-1:0] PC_RESET  = 16'h0000;
   localparam logic [PC_W-1:0] PC_STEP   = 16'h0001;
   localparam logic [1:0]      RST_SYNC0 = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Branch conditions
   typedef enum logic [COND_W-1:0] {
      branch_unsigned_at_least = 4'h0,
      branch_unsigned_below    = 4'h1,
      branch_negative          = 4'h2,
      branch_nonnegative       = 4'h3,
      branch_signed_at_least   = 4'h4,
      branch_signed_below      = 4'h5,
      branch_half_carry_on     = 4'h6,
      branch_half_carry_off    = 4'h7,
      branch_bit_copy_on       = 4'h8,
      branch_bit_copy_off      = 4'h9,
      branch_overflow_on       = 4'hA,
      branch_overflow_off      = 4'hB,
      branch_irq_allowed       = 4'hC,
      branch_irq_blocked       = 4'hD
   } cond_e;

   // Unit states
   typedef enum logic [0:0] {
      ST_IDLE  = 1'h0,
      ST_FLUSH = 1'h1
   } state_e;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic irq_en;
      logic bit_copy;
      logic half_carry;
      logic sign;
      logic overflow;
      logic negative;
      logic zero;
      logic carry;
   } flags_s;

   typedef struct packed {
      logic [COND_W-1:0] cond;
      logic [OFS_W-1:0]  offset;
      logic [PC_W-1:0]   program_counter;
   } req_s;

   typedef struct packed {
      logic            pc_load;
      logic [PC_W-1:0] program_counter;
      logic            taken;
      logic            flush;
      logic            done;
      logic            illegal;
   } resp_s;

   localparam resp_s RESP_RESET = '{pc_load: 1'b0, program_counter: PC_RESET, taken: 1'b0,
                                    flush: 1'b0, done: 1'b0, illegal: 1'b0};

endpackage

// ---- logic/branch_cond_eval.sv ----
// Combinational condition test for one branch code against the status flags.
// Assumes flags are stable for the cycle in which the code is presented.
`timescale 1ns/100ps

module branch_cond_eval (
   // Condition and flags
   input  wire logic [branch_pkg::COND_W-1:0] cond_i,
   input  wire branch_pkg::flags_s            flags_i,
   // Verdict
   output logic                               take_o,
   output logic                               illegal_o
);

   always_comb begin
      take_o    = 1'b0;
      illegal_o = 1'b0;
      case (cond_i)
         branch_pkg::branch_unsigned_at_least: take_o = ~flags_i.carry;
         branch_pkg::branch_unsigned_below:    take_o = flags_i.carry;
         branch_pkg::branch_negative:          take_o = flags_i.negative;
         branch_pkg::branch_nonnegative:       take_o = ~flags_i.negative;
         branch_pkg::branch_signed_at_least:   take_o = ~(flags_i.negative ^ flags_i.overflow);
         branch_pkg::branch_signed_below:      take_o = flags_i.negative ^ flags_i.overflow;
         branch_pkg::branch_half_carry_on:     take_o = flags_i.half_carry;
         branch_pkg::branch_half_carry_off:    take_o = ~flags_i.half_carry;
         branch_pkg::branch_bit_copy_on:       take_o = flags_i.bit_copy;
         branch_pkg::branch_bit_copy_off:      take_o = ~flags_i.bit_copy;
         branch_pkg::branch_overflow_on:       take_o = flags_i.overflow;
         branch_pkg::branch_overflow_off:      take_o = ~flags_i.overflow;
         branch_pkg::branch_irq_allowed:       take_o = flags_i.irq_en;
         branch_pkg::branch_irq_blocked:       take_o = ~flags_i.irq_en;
         // Unused codes never redirect; they are reported instead
         default:                              illegal_o = 1'b1;
      endcase
   end

endmodule

// ---- logic/cond_branch_unit.sv ----
// Conditional relative-branch unit: tests status flags, redirects or falls through.
// Assumes decode presents one branch at a time with its own address, flags from the
// status register on the same clock, and a fetch stage that obeys pc_load and flush.
//
// Behaviour
// - Same-or-higher taken when carry is 0; lower taken when carry is 1.
// - Branch-on-negative redirects only when the negative flag is 1.
// - Branch-on-nonnegative redirects only when the negative flag is 0.
// - Signed at-least taken only when negative xor overflow is 0.
// - Signed below taken only when negative xor overflow is 1.
// - Half-carry-on branch redirects only when half carry is 1.
// - Half-carry-off branch redirects only when half carry is 0.
// - Bit-copy-on branch taken only when the bit-copy flag is 1.
// - Bit-copy-off branch taken only when the bit-copy flag is 0.
// - Overflow-on branch redirects only when overflow is 1.
// - Overflow-off branch redirects only when overflow is 0.
// - Irq-allowed branch taken only when global interrupt enable is 1.
// - Irq-blocked branch taken only when global interrupt enable is 0.
// - Taken target is address plus offset plus one; flags untouched; one or two cycles.
`timescale 1ns/100ps

module cond_branch_unit (
   // Clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 rst_n_i,
   // Branch request from decode
   input  wire logic                 req_valid_i,
   input  wire branch_pkg::req_s     req_i,
   output logic                      req_ready_o,
   // Status register view
   input  wire branch_pkg::flags_s   flags_i,
   // Answer to fetch
   output branch_pkg::resp_s         resp_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   // Asynchronous assertion, release aligned to the clock through two stages.

   logic [1:0] rst_sync_q;
   logic [1:0] rst_sync_d;
   logic       rst_core_n;

   always_comb begin
      rst_sync_d = {rst_sync_q[0], 1'b1};
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_q <= branch_pkg::RST_SYNC0;
      end else begin
         rst_sync_q <= rst_sync_d;
      end
   end

   assign rst_core_n = rst_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // Condition evaluation

   logic cond_take;
   logic cond_illegal;

   branch_cond_eval u_cond_eval (
      .cond_i    (req_i.cond),
      .flags_i   (flags_i),
      .take_o    (cond_take),
      .illegal_o (cond_illegal)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Target arithmetic
   // Both candidate addresses are formed every cycle; the verdict only picks one.
   // Wrap at the top of the address space is deliberate, as on the core itself.

   logic [branch_pkg::PC_W-1:0] offset_sext;
   logic [branch_pkg::PC_W-1:0] pc_fall;
   logic [branch_pkg::PC_W-1:0] pc_taken;

   always_comb begin
      offset_sext = {{branch_pkg::SEXT_W{req_i.offset[branch_pkg::OFS_W-1]}}, req_i.offset};
      pc_fall     = req_i.program_counter + branch_pkg::PC_STEP;
      pc_taken    = pc_fall + offset_sext;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   // Idle accepts a request. A taken branch spends one more cycle in flush so
   // the word already fetched behind the branch is thrown away.

   branch_pkg::state_e state_q;
   branch_pkg::state_e state_d;
   branch_pkg::resp_s  resp_q;
   branch_pkg::resp_s  resp_d;
   logic               ready_q;
   logic               ready_d;
   logic               accept;

   assign accept = req_valid_i & ready_q;

   always_comb begin
      state_d = state_q;
      ready_d = ready_q;
      resp_d  = resp_q;
      // Strobes last one cycle; the address stays until the next answer
      resp_d.pc_load = 1'b0;
      resp_d.flush   = 1'b0;
      resp_d.done    = 1'b0;
      resp_d.illegal = 1'b0;
      case (state_q)
         branch_pkg::ST_IDLE: begin
            // Idle takes requests again, from the second cycle after reset on (ready resets to 0)
            ready_d = 1'b1;
            if (accept) begin
               resp_d.pc_load = 1'b1;
               resp_d.illegal = cond_illegal;
               if (cond_take) begin
                  // Taken: load target, discard prefetch, finish next cycle
                  resp_d.program_counter = pc_taken;
                  resp_d.taken           = 1'b1;
                  resp_d.flush           = 1'b1;
                  ready_d                = 1'b0;
                  state_d                = branch_pkg::ST_FLUSH;
               end else begin
                  // Not taken: next word, done in this one cycle
                  resp_d.program_counter = pc_fall;
                  resp_d.taken           = 1'b0;
                  resp_d.done            = 1'b1;
               end
            end
         end
         branch_pkg::ST_FLUSH: begin
            // Second cycle of a taken branch
            resp_d.done = 1'b1;
            ready_d     = 1'b1;
            state_d     = branch_pkg::ST_IDLE;
         end
         default: begin
            state_d = branch_pkg::ST_IDLE;
            ready_d = 1'b1;
         end
      endcase
   end

   // No status flag is written from here: the unit only reads them.
   always_ff @(posedge clk_sys_i or negedge rst_core_n) begin
      if (!rst_core_n) begin
         state_q <= branch_pkg::ST_IDLE;
         ready_q <= 1'b0;
         resp_q  <= branch_pkg::RESP_RESET;
      end else begin
         state_q <= state_d;
         ready_q <= ready_d;
         resp_q  <= resp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign req_ready_o = ready_q;
   assign resp_o      = resp_q;

endmodule

// ---- sim/branch_unit_sva.sv ----
// Concurrent checks on the ports of the conditional branch unit.
// Assumes one clock; checks are off while the reset pin is low.
`timescale 1ns/100ps
module branch_unit_sva (
   // Clock and reset
   input wire logic               clk_sys_i,
   input wire logic               rst_n_i,
   // Unit ports
   input wire logic               req_valid_i,
   input wire branch_pkg::req_s   req_i,
   input wire logic               req_ready_o,
   input wire branch_pkg::flags_s flags_i,
   input wire branch_pkg::resp_s  resp_o
);
   logic        acc;
   logic        nv;
   logic [15:0] hit;
   assign acc = req_valid_i & req_ready_o;
   assign nv  = flags_i.negative ^ flags_i.overflow;
   // One verdict bit per condition code; codes 14 and 15 never branch
   assign hit = {2'h0, ~flags_i.irq_en, flags_i.irq_en, ~flags_i.overflow, flags_i.overflow,
                 ~flags_i.bit_copy, flags_i.bit_copy, ~flags_i.half_carry, flags_i.half_carry,
                 nv, ~nv, ~flags_i.negative, flags_i.negative, flags_i.carry, ~flags_i.carry};
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence acc_s;
      acc;
   endsequence
   sequence flush_s;
      resp_o.flush && !req_ready_o ##1 resp_o.done && req_ready_o && !resp_o.pc_load;
   endsequence
   load_follows_a: assert property (acc_s |=> resp_o.pc_load) else $error("no load after accept");
   load_cause_a: assert property (resp_o.pc_load |-> $past(acc)) else $error("load without request");
   cond_verdict_a: assert property (
      acc_s |=> resp_o.taken == $past(hit[req_i.cond])) else $error("wrong branch verdict");
   taken_target_a: assert property (
      acc_s ##1 resp_o.taken |-> resp_o.program_counter ==
      $past(req_i.program_counter + {{9{req_i.offset[6]}}, req_i.offset}) + 16'h0001)
      else $error("wrong branch target");
   taken_steps_a: assert property (acc_s ##1 resp_o.taken |-> flush_s) else $error("taken timing");
   fall_through_a: assert property (
      acc_s ##1 !resp_o.taken |-> resp_o.done && !resp_o.flush &&
      resp_o.program_counter == $past(req_i.program_counter) + 16'h0001) else $error("fall through");
   quick_ready_a: assert property (acc_s ##1 !resp_o.taken |-> req_ready_o) else $error("ready low");
   pc_hold_a: assert property (!acc |=> $stable(resp_o.program_counter) && $stable(resp_o.taken))
      else $error("answer changed without request");
endmodule
bind cond_branch_unit branch_unit_sva i_branch_unit_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .flags_i(flags_i), .resp_o(resp_o));

// ---- sim/fetch_model.sv ----
// Decode side model: presents queued branches with their flags, one at a time.
// Assumes the unit's ready is registered on the same clock.
`timescale 1ns/100ps
module fetch_model (
   // Clock and handshake
   input  wire logic         clk_sys_i,
   input  wire logic         req_ready_i,
   // Request and flags
   output logic              req_valid_o,
   output branch_pkg::req_s  req_o,
   output branch_pkg::flags_s flags_o
);
   logic [34:0] pend [$];
   logic        fire;
   task push(input logic [34:0] r);
      pend.push_back(r);
   endtask
   always @(posedge clk_sys_i) begin
      fire = req_valid_o & req_ready_i;
      #1;
      // Valid starts unknown; treat anything but a clean 1 as no request pending
      if (fire || req_valid_o !== 1'h1) begin
         if (pend.size() > 0) begin
            req_valid_o = 1'h1;
            {flags_o, req_o} = pend.pop_front();
         end else begin
            // Idle lines toggle so that no stale request can pass for a real one
            req_valid_o = 1'h0;
            {flags_o, req_o} = ~{flags_o, req_o};
         end
      end
   end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the conditional branch unit.
// Assumes the decode model in fetch_model and the bound checker.
`timescale 1ns/100ps
module testbench;
   logic               clk_sys_i = 1'h0;
   logic               rst_n_i;
   logic               req_valid_i;
   logic               req_ready_o;
   branch_pkg::req_s   req_i;
   branch_pkg::flags_s flags_i;
   branch_pkg::resp_s  resp_o;
   int                 error_cnt = 0;
   int                 comparisons = 0;
   logic [7:0]         pats [3] = '{8'h00, 8'hFF, 8'h04};
   always #2 clk_sys_i = ~clk_sys_i;
   fetch_model i_fetch_model (.clk_sys_i(clk_sys_i), .req_ready_i(req_ready_o), .req_valid_o(req_valid_i),
      .req_o(req_i), .flags_o(flags_i));
   cond_branch_unit i_cond_branch_unit (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .req_ready_o(req_ready_o), .flags_i(flags_i), .resp_o(resp_o));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [20:0] e, input logic [20:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task end_of_test;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task wait_for(input bit rdy);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end while ((rdy ? req_ready_o : resp_o.pc_load) !== 1'h1 && n < 20);
      if ((rdy ? req_ready_o : resp_o.pc_load) !== 1'h1) begin
         error_cnt++;
         end_of_test;
      end
   endtask
   function automatic logic hit(input logic [3:0] c, input branch_pkg::flags_s f);
      logic [15:0] v;
      v = {2'h0, ~f.irq_en, f.irq_en, ~f.overflow, f.overflow, ~f.bit_copy, f.bit_copy, ~f.half_carry,
           f.half_carry, f.negative ^ f.overflow, f.negative ~^ f.overflow, ~f.negative, f.negative, f.carry, ~f.carry};
      return v[c];
   endfunction
   task branch_one(input logic [3:0] c, input logic [7:0] f, input logic [6:0] o, input logic [15:0] a);
      logic t;
      t = hit(c, f);
      i_fetch_model.push({f, c, o, a});
      wait_for(1'b0);
      chk("taken", t, resp_o.taken);
      chk("pc", 16'(a + (t ? {{9{o[6]}}, o} : 16'h0000) + 16'h0001), resp_o.program_counter);
      chk("flush", t, resp_o.flush);
      chk("illegal", c > 4'hD, resp_o.illegal);
      if (t) begin
         @(posedge clk_sys_i);
         #1;
      end
      chk("done", 1'h1, resp_o.done);
   endtask
   task back_to_back;
      i_fetch_model.push({8'h01, 4'h0, 7'h11, 16'h0200});
      i_fetch_model.push({8'h00, 4'h1, 7'h22, 16'h0300});
      wait_for(1'b0);
      chk("pc", 16'h0201, resp_o.program_counter);
      @(posedge clk_sys_i);
      #1;
      chk("load", 1'h1, resp_o.pc_load);
      chk("pc", 16'h0301, resp_o.program_counter);
   endtask
   task taken_then_next;
      i_fetch_model.push({8'h00, 4'h0, 7'h40, 16'h0010});
      i_fetch_model.push({8'h00, 4'h2, 7'h01, 16'h1234});
      wait_for(1'b0);
      chk("pc", 16'hFFD1, resp_o.program_counter);
      chk("ready", 1'h0, req_ready_o);
      @(posedge clk_sys_i);
      #1;
      chk("load", 1'h0, resp_o.pc_load);
      @(posedge clk_sys_i);
      #1;
      chk("pc", 16'h1235, resp_o.program_counter);
   endtask
   task mid_reset;
      i_fetch_model.push({8'h00, 4'h0, 7'h05, 16'h0100});
      wait_for(1'b0);
      rst_n_i = 1'h0;
      @(posedge clk_sys_i);
      #1;
      chk("ready", 1'h0, req_ready_o);
      chk("resp", 21'h000000, resp_o);
      rst_n_i = 1'h1;
      wait_for(1'b1);
      branch_one(4'h3, 8'h00, 7'h7F, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n_i = 1'h0;
      repeat (4) @(posedge clk_sys_i);
      #1 rst_n_i = 1'h1;
      wait_for(1'b1);
      for (int p = 0; p < 3; p++)
         for (int c = 0; c < 16; c++)
            branch_one(4'(c), pats[p], 7'(c * 9 + p * 50), 16'hFFC0 + 16'(c * 5));
      back_to_back;
      taken_then_next;
      mid_reset;
      end_of_test;
   end
endmodule
